// >>> cac_clock_ctrl.sv
`timescale 1ns/10ps
module cac_clock_ctrl
   import cac_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic ce,
   input wire logic reg_wr,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   input wire logic pll_clk,
   input wire logic bclk_primary,
   input wire logic bclk_secondary,
   input wire logic ctrl_clk,
   input wire logic osc_clk,
   input wire logic dsp_clk,
   input wire logic audio_clk,
   input wire logic audio_clk_present,
   input wire logic aux_conv_request,
   output logic general_clock_output,
   output logic aux_conv_clock
);
   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   logic [7:0] src_cfg;
   logic [7:0] div_cfg;
   logic [7:0] aux_cfg;
   logic [7:0] next_src_cfg;
   logic [7:0] next_div_cfg;
   logic [7:0] next_aux_cfg;
   logic [7:0] next_rdata;
   logic [7:0] status;

   always_comb begin
      next_src_cfg = src_cfg;
      next_div_cfg = div_cfg;
      next_aux_cfg = aux_cfg;
      if (reg_wr) begin
         case (reg_addr)
            CAC_ADDR_GCO_SRC: next_src_cfg = reg_wdata & CAC_SRC_FIELD_MASK;
            CAC_ADDR_GCO_DIV: next_div_cfg = reg_wdata;
            CAC_ADDR_AUX_CFG: next_aux_cfg = reg_wdata;
            default: ;
         endcase
      end
      case (reg_addr)
         CAC_ADDR_GCO_SRC: next_rdata = src_cfg;
         CAC_ADDR_GCO_DIV: next_rdata = div_cfg;
         CAC_ADDR_AUX_CFG: next_rdata = aux_cfg;
         CAC_ADDR_STATUS: next_rdata = status;
         default: next_rdata = 8'h00;
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         src_cfg <= CAC_RST_GCO_SRC;
         div_cfg <= CAC_RST_GCO_DIV;
         aux_cfg <= CAC_RST_AUX_CFG;
         reg_rdata <= 8'h00;
      end else if (ce) begin
         src_cfg <= next_src_cfg;
         div_cfg <= next_div_cfg;
         aux_cfg <= next_aux_cfg;
         reg_rdata <= next_rdata;
      end
   end

   // ---------------------------------------------------------------
   // Pin synchronisers
   // ---------------------------------------------------------------
   logic [CAC_NUM_PINS-1:0] pins;
   logic [CAC_NUM_PINS-1:0] sync1;
   logic [CAC_NUM_PINS-1:0] sync2;
   assign pins = {audio_clk, dsp_clk, osc_clk, ctrl_clk, bclk_secondary, bclk_primary, pll_clk};

   genvar gi;
   generate
      for (gi = 0; gi < CAC_NUM_PINS; gi++) begin : g_sync
         always_ff @(posedge clk_sys) begin
            if (rst) begin
               sync1[gi] <= 1'b0;
               sync2[gi] <= 1'b0;
            end else if (ce) begin
               sync1[gi] <= pins[gi];
               sync2[gi] <= sync1[gi];
            end
         end
      end
   endgenerate

   // ---------------------------------------------------------------
   // Clock output path
   // ---------------------------------------------------------------
   logic [2:0] act_sel;
   logic [2:0] next_act_sel;
   logic gco_src;
   logic [7:0] gco_ratio;
   logic gco_run;
   logic gco_wrap;
   logic gco_q;
   logic gco_en;

   assign gco_ratio = (div_cfg[6:0] == 7'h00) ? CAC_RATIO_MAX : {1'b0, div_cfg[6:0]};

   always_comb begin
      // swap only while stopped, a live swap can cut a level short
      next_act_sel = act_sel;
      if (!gco_run) begin
         next_act_sel = src_cfg[2:0];
      end
      // enable bit, held off until a pending swap is done
      gco_en = div_cfg[CAC_DIV_EN_BIT] && (act_sel == src_cfg[2:0]);
      // source mux, reserved codes give no clock
      if (act_sel <= CAC_SRC_DSP) begin
         gco_src = sync2[act_sel];
      end else begin
         gco_src = 1'b0;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         act_sel <= CAC_SRC_PLL;
      end else if (ce) begin
         act_sel <= next_act_sel;
      end
   end

   cac_divider u_gco_div (
      .clk_sys(clk_sys),
      .rst(rst),
      .ce(ce),
      .src_lvl(gco_src),
      .enable(gco_en),
      .ratio(gco_ratio),
      .div_out(gco_q),
      .running(gco_run),
      .wrap(gco_wrap)
   );

   // ---------------------------------------------------------------
   // Auxiliary converter clock path
   // ---------------------------------------------------------------
   logic aux_use_osc;
   logic aux_en;
   logic [7:0] aux_ratio;
   logic [7:0] aux_auto_ratio;
   logic aux_src;
   logic aux_run;
   logic aux_wrap;
   logic aux_q;
   logic aux_sel_q;
   logic next_aux_sel;
   logic aux_div_en;

   always_comb begin
      if (!aux_cfg[CAC_SRC_AUTO_DIS_BIT]) begin
         aux_use_osc = !audio_clk_present;
      end else begin
         aux_use_osc = aux_cfg[CAC_SRC_MAN_SEL_BIT];
      end
      aux_en = aux_cfg[CAC_EN_AUTO_DIS_BIT] ? aux_cfg[CAC_MAN_EN_BIT] : aux_conv_request;
      case (aux_cfg[CAC_FREQ_LSB +: 2])
         2'h0: aux_auto_ratio = CAC_AUTO_RATIO_6M;
         2'h1: aux_auto_ratio = CAC_AUTO_RATIO_3M;
         2'h2: aux_auto_ratio = CAC_AUTO_RATIO_1M5;
         default: aux_auto_ratio = CAC_AUTO_RATIO_12M;
      endcase
      if (aux_cfg[CAC_EN_AUTO_DIS_BIT]) begin
         aux_ratio = 8'h01 << aux_cfg[CAC_MAN_DIV_LSB +: 2];
      end else begin
         aux_ratio = aux_auto_ratio;
      end
      // aux source swaps only while stopped
      next_aux_sel = !aux_run ? aux_use_osc : aux_sel_q;
      aux_div_en = aux_en && (aux_sel_q == aux_use_osc);
      aux_src = aux_sel_q ? sync2[CAC_SRC_OSC] : sync2[CAC_PIN_AUDIO];
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         aux_sel_q <= 1'b0;
      end else if (ce) begin
         aux_sel_q <= next_aux_sel;
      end
   end

   cac_divider u_aux_div (
      .clk_sys(clk_sys),
      .rst(rst),
      .ce(ce),
      .src_lvl(aux_src),
      .enable(aux_div_en),
      .ratio(aux_ratio),
      .div_out(aux_q),
      .running(aux_run),
      .wrap(aux_wrap)
   );

   // Status: outputs come from the divider flops directly
   assign status = {3'h0, gco_run, aux_run, aux_sel_q, aux_en, aux_use_osc};
   assign general_clock_output = gco_q;
   assign aux_conv_clock = aux_q;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   a_div_zero_max: assert property (@(posedge clk_sys) disable iff (rst)
      div_cfg[6:0] == 7'h00 |-> gco_ratio == 8'h80) else $error("code zero not 128");
   a_src_osc_pick: assert property (@(posedge clk_sys) disable iff (rst)
      act_sel == 3'h4 |-> gco_src == sync2[4]) else $error("oscillator source wrong");
   a_src_reserved: assert property (@(posedge clk_sys) disable iff (rst)
      act_sel > 3'h5 |-> !gco_src) else $error("reserved source passes clock");
   a_aux_auto_src: assert property (@(posedge clk_sys) disable iff (rst)
      !aux_cfg[5] |-> aux_use_osc == !audio_clk_present) else $error("auto source wrong");
   a_aux_man_src: assert property (@(posedge clk_sys) disable iff (rst)
      aux_cfg[5] |-> aux_use_osc == aux_cfg[4]) else $error("manual source wrong");
   a_aux_auto_en: assert property (@(posedge clk_sys) disable iff (rst)
      !aux_cfg[3] |-> aux_en == aux_conv_request) else $error("auto enable wrong");
   a_aux_man_en: assert property (@(posedge clk_sys) disable iff (rst)
      aux_cfg[3] |-> aux_en == aux_cfg[2]) else $error("manual enable wrong");
   a_aux_man_div: assert property (@(posedge clk_sys) disable iff (rst)
      (aux_cfg[3] && aux_cfg[1:0] == 2'h3) |-> aux_ratio == 8'h08) else $error("div 8 wrong");
   a_aux_freq_mode: assert property (@(posedge clk_sys) disable iff (rst)
      (!aux_cfg[3] && aux_cfg[7:6] == 2'h1) |-> aux_ratio == 8'h04) else $error("3 MHz wrong");
   a_gco_off: assert property (@(posedge clk_sys) disable iff (rst)
      (!div_cfg[7] && !gco_run && ce) |=> !general_clock_output)
      else $error("clock output toggles while disabled");
   c_gco_run: cover property (@(posedge clk_sys) disable iff (rst) gco_run && gco_wrap);
   c_aux_osc: cover property (@(posedge clk_sys) disable iff (rst) aux_run && aux_sel_q);
   c_aux_audio: cover property (@(posedge clk_sys) disable iff (rst) aux_run && !aux_sel_q);
endmodule : cac_clock_ctrl

// >>> cac_divider.sv
`timescale 1ns/10ps
module cac_divider
   import cac_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic ce,
   input wire logic src_lvl,
   input wire logic enable,
   input wire logic [7:0] ratio,
   output logic div_out,
   output logic running,
   output logic wrap
);
   cac_state_e state;
   cac_state_e next_state;
   logic prev;
   logic [7:0] cnt;
   logic [7:0] next_cnt;
   logic [7:0] act;
   logic [7:0] next_act;
   logic next_out;
   logic next_wrap;
   logic rise;
   logic boundary;

   assign running = (state == CAC_RUN);
   assign rise = src_lvl & ~prev;
   assign boundary = rise && (cnt == act - 8'h01);

   always_comb begin
      next_state = state;
      next_cnt = cnt;
      next_act = act;
      next_wrap = 1'b0;
      if (state == CAC_IDLE) begin
         // Start aligned to a source edge
         if (enable && rise) begin
            next_state = CAC_RUN;
            next_act = ratio;
            next_cnt = 8'h00;
         end
      end else if (boundary) begin
         next_wrap = 1'b1;
         next_cnt = 8'h00;
         if (enable) begin
            next_act = ratio;
         end else begin
            next_state = CAC_IDLE;
         end
      end else if (rise) begin
         next_cnt = cnt + 8'h01;
      end
      if (next_state == CAC_IDLE) begin
         next_out = 1'b0;
      end else if (next_act == 8'h01) begin
         next_out = src_lvl;
      end else begin
         next_out = next_cnt < ((next_act + 8'h01) >> 1);
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         state <= CAC_IDLE;
         prev <= 1'b0;
         cnt <= 8'h00;
         act <= 8'h01;
         div_out <= 1'b0;
         wrap <= 1'b0;
      end else if (ce) begin
         state <= next_state;
         prev <= src_lvl;
         cnt <= next_cnt;
         act <= next_act;
         div_out <= next_out;
         wrap <= next_wrap;
      end
   end

   a_idle_out_low: assert property (@(posedge clk_sys) disable iff (rst)
      !running |-> !div_out) else $error("divided output high while idle");
   a_ratio_at_wrap: assert property (@(posedge clk_sys) disable iff (rst)
      ($past(running) && running && act != $past(act)) |-> wrap)
      else $error("ratio changed mid-period");
   a_disabled_stays: assert property (@(posedge clk_sys) disable iff (rst)
      (!running && !enable) |=> !running) else $error("divider started while disabled");
   c_div_wrap: cover property (@(posedge clk_sys) disable iff (rst) wrap && act > 8'h02);
endmodule : cac_divider

// >>> cac_pkg.sv
package cac_pkg;
   // ---------------------------------------------------------------
   // Register map
   // ---------------------------------------------------------------
   localparam logic [7:0] CAC_ADDR_GCO_SRC = 8'h46;
   localparam logic [7:0] CAC_ADDR_GCO_DIV = 8'h47;
   localparam logic [7:0] CAC_ADDR_AUX_CFG = 8'h49;
   localparam logic [7:0] CAC_ADDR_STATUS = 8'h4A;
   localparam logic [7:0] CAC_RST_GCO_SRC = 8'h00;
   localparam logic [7:0] CAC_RST_GCO_DIV = 8'h01;
   localparam logic [7:0] CAC_RST_AUX_CFG = 8'h00;
   localparam logic [7:0] CAC_SRC_FIELD_MASK = 8'h07;
   // ---------------------------------------------------------------
   // Field positions
   // ---------------------------------------------------------------
   localparam int CAC_DIV_EN_BIT = 7;
   localparam int CAC_FREQ_LSB = 6;
   localparam int CAC_SRC_AUTO_DIS_BIT = 5;
   localparam int CAC_SRC_MAN_SEL_BIT = 4;
   localparam int CAC_EN_AUTO_DIS_BIT = 3;
   localparam int CAC_MAN_EN_BIT = 2;
   localparam int CAC_MAN_DIV_LSB = 0;
   // ---------------------------------------------------------------
   // Source codes and ratios
   // ---------------------------------------------------------------
   localparam logic [2:0] CAC_SRC_PLL = 3'h0;
   localparam logic [2:0] CAC_SRC_BCLK_PRI = 3'h1;
   localparam logic [2:0] CAC_SRC_BCLK_SEC = 3'h2;
   localparam logic [2:0] CAC_SRC_CTRL_CLK = 3'h3;
   localparam logic [2:0] CAC_SRC_OSC = 3'h4;
   localparam logic [2:0] CAC_SRC_DSP = 3'h5;
   localparam int CAC_NUM_PINS = 7;
   localparam int CAC_PIN_AUDIO = 6;
   localparam logic [7:0] CAC_RATIO_MAX = 8'h80;
   // Auto ratios from a ~12 MHz base: 6, 3, 1.5, 12 MHz
   localparam logic [7:0] CAC_AUTO_RATIO_6M = 8'h02;
   localparam logic [7:0] CAC_AUTO_RATIO_3M = 8'h04;
   localparam logic [7:0] CAC_AUTO_RATIO_1M5 = 8'h08;
   localparam logic [7:0] CAC_AUTO_RATIO_12M = 8'h01;
   typedef enum logic {CAC_IDLE = 1'b0, CAC_RUN = 1'b1} cac_state_e;
endpackage : cac_pkg

// >>> tb.sv
`timescale 1ns/10ps
module tb;
   import cac_pkg::*;
   // ---------------------------------------------------------------
   // Stimulus and design
   // ---------------------------------------------------------------
   logic clk_sys = 1'b0;
   logic rst, ce, reg_wr, audio_clk_present, aux_conv_request;
   logic [7:0] reg_addr, reg_wdata, reg_rdata;
   logic general_clock_output, aux_conv_clock;
   logic [6:0] src;
   logic [1:0] prev_out;
   int tick = 0;
   int failures = 0;
   int checked = 0;
   int run [2];

   initial begin
      forever #2 clk_sys = ~clk_sys;
   end

   // Pin k has half period 4+2k cycles, so each source is told apart by its period
   always @(negedge clk_sys) tick <= tick + 1;
   always_comb begin
      for (int k = 0; k < 7; k++) src[k] = ((tick / (4 + 2 * k)) % 2) == 1;
   end

   cac_clock_ctrl cac_clock_ctrl_inst (
      .clk_sys(clk_sys), .rst(rst), .ce(ce), .reg_wr(reg_wr), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .pll_clk(src[0]),
      .bclk_primary(src[1]), .bclk_secondary(src[2]), .ctrl_clk(src[3]),
      .osc_clk(src[4]), .dsp_clk(src[5]), .audio_clk(src[6]),
      .audio_clk_present(audio_clk_present), .aux_conv_request(aux_conv_request),
      .general_clock_output(general_clock_output), .aux_conv_clock(aux_conv_clock)
   );

   // ---------------------------------------------------------------
   // Runt watch: no level may last a single cycle
   // ---------------------------------------------------------------
   always @(negedge clk_sys) begin : runt_watch
      logic [1:0] cur;
      cur = {aux_conv_clock, general_clock_output};
      for (int i = 0; i < 2; i++) begin
         if (rst) begin
            run[i] = 0;
         end else if (cur[i] === prev_out[i]) begin
            run[i]++;
         end else begin
            if (run[i] == 1) begin
               failures++;
               $display("BAD runt on output %0d expected 2 seen %0d", i, run[i]);
            end
            run[i] = 1;
         end
         prev_out[i] = cur[i];
      end
   end

   // ---------------------------------------------------------------
   // Shared tasks
   // ---------------------------------------------------------------
   task automatic chk8(input string nm, input logic [7:0] exp, input logic [7:0] got);
      checked++;
      if (got !== exp) begin
         failures++;
         $display("BAD %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk8

   task automatic chki(input string nm, input int exp, input int got);
      checked++;
      if (got != exp) begin
         failures++;
         $display("BAD %s expected %0d seen %0d", nm, exp, got);
      end
   endtask : chki

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk_sys);
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      @(negedge clk_sys);
      reg_wr = 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [7:0] e, input string nm);
      @(negedge clk_sys);
      reg_addr = a;
      @(negedge clk_sys);
      chk8(nm, e, reg_rdata);
   endtask : rd

   function automatic logic outp(input bit a);
      return a ? aux_conv_clock : general_clock_output;
   endfunction : outp

   // Bounded waits so a dead output reads as zero width, not a hang
   task automatic meas(input bit a, output int hi, output int per);
      int n;
      n = 0;
      while (outp(a) !== 1'b0 && n < 5000) begin
         @(negedge clk_sys);
         n++;
      end
      while (outp(a) !== 1'b1 && n < 5000) begin
         @(negedge clk_sys);
         n++;
      end
      hi = 0;
      while (outp(a) === 1'b1 && hi < 5000) begin
         @(negedge clk_sys);
         hi++;
      end
      per = hi;
      while (outp(a) === 1'b0 && per < 5000) begin
         @(negedge clk_sys);
         per++;
      end
   endtask : meas

   // First period skipped: new settings land only at a period end
   task automatic per_chk(input string nm, input bit a, input int p, input int n);
      int hi, per;
      meas(a, hi, per);
      meas(a, hi, per);
      chki({nm, " high"}, (n == 1) ? p / 2 : ((n + 1) / 2) * p, hi);
      chki({nm, " period"}, n * p, per);
   endtask : per_chk

   task automatic still_low(input bit a, input int w, input string nm);
      int n;
      n = 0;
      repeat (w) @(negedge clk_sys);
      repeat (300) begin
         @(negedge clk_sys);
         if (outp(a) !== 1'b0) n++;
      end
      chki(nm, 0, n);
   endtask : still_low

   task automatic stop_test;
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : stop_test

   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic regs_test;
      rd(CAC_ADDR_GCO_DIV, CAC_RST_GCO_DIV, "div reset");
      rd(CAC_ADDR_AUX_CFG, CAC_RST_AUX_CFG, "aux reset");
      rd(CAC_ADDR_GCO_SRC, CAC_RST_GCO_SRC, "src reset");
      // No audio clock: auto source picks the oscillator
      rd(CAC_ADDR_STATUS, 8'h05, "status reset");
      wr(CAC_ADDR_GCO_SRC, 8'hFF);
      rd(CAC_ADDR_GCO_SRC, 8'h07, "src mask");
      wr(8'h50, 8'hA5);
      rd(8'h50, 8'h00, "unmapped");
      wr(CAC_ADDR_AUX_CFG, 8'hB6);
      rd(CAC_ADDR_AUX_CFG, 8'hB6, "aux rw");
      wr(CAC_ADDR_AUX_CFG, 8'h00);
      // Clock enable low freezes the registers
      ce = 1'b0;
      wr(CAC_ADDR_AUX_CFG, 8'hFF);
      ce = 1'b1;
      rd(CAC_ADDR_AUX_CFG, 8'h00, "aux frozen");
      still_low(0, 10, "gco off at reset");
      still_low(1, 10, "aux off without request");
   endtask : regs_test

   task automatic gco_src_test;
      wr(CAC_ADDR_GCO_DIV, 8'h81);
      for (int k = 0; k < 6; k++) begin
         wr(CAC_ADDR_GCO_SRC, k[7:0]);
         per_chk("gco src", 0, 8 + 4 * k, 1);
      end
      for (int k = 6; k < 8; k++) begin
         wr(CAC_ADDR_GCO_SRC, k[7:0]);
         still_low(0, 300, "reserved src");
      end
      wr(CAC_ADDR_GCO_SRC, {5'h00, CAC_SRC_PLL});
   endtask : gco_src_test

   task automatic gco_ratio_test;
      int codes [4] = '{2, 3, 127, 0};
      for (int i = 0; i < 4; i++) begin
         wr(CAC_ADDR_GCO_DIV, {1'b1, codes[i][6:0]});
         per_chk("gco ratio", 0, 8, (codes[i] == 0) ? 128 : codes[i]);
      end
      wr(CAC_ADDR_GCO_DIV, 8'h01);
      still_low(0, 1100, "gco disabled");
   endtask : gco_ratio_test

   task automatic aux_manual_test;
      for (int d = 0; d < 4; d++) begin
         wr(CAC_ADDR_AUX_CFG, {6'h0F, d[1:0]});
         per_chk("aux manual div", 1, 24, 1 << d);
      end
      // Frequency mode 3 set but ignored under manual enable
      wr(CAC_ADDR_AUX_CFG, 8'hED);
      per_chk("aux manual audio", 1, 32, 2);
      wr(CAC_ADDR_AUX_CFG, 8'h29);
      still_low(1, 300, "aux manual off");
   endtask : aux_manual_test

   task automatic aux_auto_test;
      int rt [4] = '{2, 4, 8, 1};
      aux_conv_request = 1'b1;
      // All four frequency modes run with the oscillator picked directly
      for (int m = 0; m < 4; m++) begin
         wr(CAC_ADDR_AUX_CFG, {m[1:0], 6'h30});
         per_chk("aux freq mode", 1, 24, rt[m]);
      end
      audio_clk_present = 1'b1;
      wr(CAC_ADDR_AUX_CFG, 8'h10);
      per_chk("aux auto audio", 1, 32, 2);
      audio_clk_present = 1'b0;
      per_chk("aux auto osc", 1, 24, 2);
      wr(CAC_ADDR_AUX_CFG, 8'h04);
      aux_conv_request = 1'b0;
      still_low(1, 300, "aux auto idle");
   endtask : aux_auto_test

   // ---------------------------------------------------------------
   // Main sequence and watchdog
   // ---------------------------------------------------------------
   initial begin
      rst = 1'b1;
      ce = 1'b1;
      reg_wr = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      audio_clk_present = 1'b0;
      aux_conv_request = 1'b0;
      repeat (3) @(negedge clk_sys);
      rst = 1'b0;
      regs_test();
      gco_src_test();
      gco_ratio_test();
      aux_manual_test();
      aux_auto_test();
      stop_test();
   end

   // Whole plan needs about 16k cycles
   initial begin
      repeat (100000) @(posedge clk_sys);
      failures++;
      $display("BAD watchdog expected done seen hang");
      stop_test();
   end
endmodule : tb
